// ===== inc/urb_pkg.sv
/*
 * urb_pkg: register map, field positions, reset values, frame constants and
 * the types shared by the receive-buffer block.
 * Assumes a single 10 MHz system clock and a 32-bit Avalon-MM slave port.
 */
`default_nettype none
package urb_pkg;
    localparam int unsigned MCLK_HZ = 10_000_000;
    localparam int unsigned MCLK_PERIOD_NS = 100;

    // byte addresses of the word registers
    localparam logic [4:0] ADDR_CSA = 5'h00;
    localparam logic [4:0] ADDR_CSB = 5'h04;
    localparam logic [4:0] ADDR_CSC = 5'h08;
    localparam logic [4:0] ADDR_DATA = 5'h0C;
    localparam logic [4:0] ADDR_BAUD = 5'h10;

    // ctrl_status_a fields
    localparam int CSA_RXC = 7;
    localparam int CSA_FE = 4;
    localparam int CSA_DOR = 3;
    localparam int CSA_PE = 2;
    // ctrl_status_b fields
    localparam int CSB_RXCIE = 7;
    localparam int CSB_RXEN = 4;
    localparam int CSB_SZ2 = 2;
    localparam int CSB_RXB8 = 1;
    // ctrl_status_c fields
    localparam int CSC_PEN = 5;
    localparam int CSC_PODD = 4;
    localparam int CSC_SBS = 3;
    localparam int CSC_SZ1 = 2;
    localparam int CSC_SZ0 = 1;

    localparam logic [2:0] SZ_9BIT = 3'h7;
    localparam logic [2:0] SZ_8BIT = 3'h3;
    localparam logic [3:0] NBITS_MIN = 4'h5;
    localparam logic [3:0] NBITS_8 = 4'h8;
    localparam logic [3:0] NBITS_MAX = 4'h9;

    // oversampling: samples per bit and the three voting samples
    localparam logic [4:0] SAMP_A = 5'h08;
    localparam logic [4:0] SAMP_B = 5'h09;
    localparam logic [4:0] SAMP_C = 5'h0A;
    localparam logic [4:0] SAMP_END = 5'h10;
    localparam logic [4:0] SAMP_FIRST = 5'h01;

    localparam logic [1:0] FIFO_FULL = 2'h2;
    localparam logic [11:0] BAUD_RST = 12'h040;
    localparam logic [2:0] SYNC_IDLE = 3'h7;

    typedef enum logic [2:0] {URB_IDLE, URB_START, URB_DATA, URB_PAR, URB_STOP} urb_rxst_e;

    typedef struct packed {
        logic [7:0] data;
        logic b8;
        logic fe;
        logic dor;
        logic pe;
    } urb_entry_s;

    typedef struct packed {
        logic [4:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } urb_avs_req_s;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } urb_avs_rsp_s;

    typedef struct packed {
        logic [2:0] sync;
        logic rx_lvl;
        logic rx_prev;
        logic [11:0] div_cnt;
        logic [11:0] baud_div;
        logic rx_en;
        logic rxcie;
        logic pen;
        logic podd;
        logic sbs;
        logic [2:0] sz;
        urb_rxst_e st;
        logic [4:0] samp;
        logic [1:0] votes;
        logic [3:0] nbits;
        logic [8:0] shreg;
        logic par_bit;
        logic hold_v;
        urb_entry_s hold;
        logic dor_pend;
        urb_entry_s [1:0] fifo;
        logic [1:0] cnt;
        logic rd_ack;
        logic [11:0] rdata;
    } urb_state_s;
endpackage
`default_nettype wire

// ===== logic/urb_rx_buffer.sv
/*
 * urb_rx_buffer: serial receiver with majority-vote sampling, a two-entry
 * receive FIFO holding data, ninth bit and error status, and an Avalon-MM
 * register slave with one wait state on reads.
 * Assumes rxd_pin is asynchronous, glob_irq_en comes from the CPU core.
 */
`timescale 1ns/100ps
`default_nettype none
module urb_rx_buffer
    import urb_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic rxd_pin,
    input wire logic glob_irq_en,
    input wire urb_avs_req_s avs_req,
    output urb_avs_rsp_s avs_rsp,
    output logic rx_pin_owned,
    output logic rx_irq
);
    urb_state_s r;
    urb_state_s n;
    urb_entry_s e;
    logic tick;
    logic fall;
    logic pop;
    logic bitv;
    logic [4:0] sn;
    logic [3:0] need;
    logic [8:0] aligned;

    function automatic logic [3:0] nbits_of(input logic [2:0] sz);
        if (sz == SZ_9BIT) begin
            return NBITS_MAX;
        end else if (sz <= SZ_8BIT) begin
            return NBITS_MIN + {1'b0, sz};
        end
        return NBITS_8;
    endfunction

    function automatic logic maj3(input logic [2:0] v);
        return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
    endfunction

    function automatic logic [11:0] readback(input urb_state_s s, input logic [4:0] a);
        logic [11:0] d;
        d = '0;
        case (a)
            ADDR_CSA: begin
                d[CSA_RXC] = (s.cnt != 2'h0);
                d[CSA_FE] = s.fifo[0].fe;
                d[CSA_DOR] = s.fifo[0].dor;
                d[CSA_PE] = s.fifo[0].pe & s.pen;
            end
            ADDR_CSB: begin
                d[CSB_RXCIE] = s.rxcie;
                d[CSB_RXEN] = s.rx_en;
                d[CSB_SZ2] = s.sz[2];
                d[CSB_RXB8] = s.fifo[0].b8;
            end
            ADDR_CSC: begin
                d[CSC_PEN] = s.pen;
                d[CSC_PODD] = s.podd;
                d[CSC_SBS] = s.sbs;
                d[CSC_SZ1] = s.sz[1];
                d[CSC_SZ0] = s.sz[0];
            end
            ADDR_DATA: begin
                if (s.cnt != 2'h0) begin
                    d[7:0] = s.fifo[0].data;
                end
            end
            ADDR_BAUD: d = s.baud_div;
            default: d = '0;
        endcase
        return d;
    endfunction

    always_comb begin
        n = r;
        e = r.hold;
        tick = 1'b0;
        need = nbits_of(r.sz);
        aligned = r.shreg >> (NBITS_MAX - need);
        // only stages two and three are compared; stage one is metastable
        n.sync = {r.sync[1:0], rxd_pin};
        if (r.sync[1] == r.sync[2]) begin
            n.rx_lvl = r.sync[2];
        end
        n.rx_prev = r.rx_lvl;
        fall = r.rx_prev & ~r.rx_lvl;
        bitv = maj3({r.votes, r.rx_lvl});
        sn = r.samp + 5'h01;

        // register slave: one wait state so read data comes from a flop
        n.rd_ack = avs_req.read & ~r.rd_ack;
        if (avs_req.read && !r.rd_ack) begin
            n.rdata = readback(r, avs_req.address);
        end
        // pop with the data latch, so a frame landing mid-read is never popped unseen
        pop = avs_req.read & ~r.rd_ack & (avs_req.address == ADDR_DATA)
            & (r.cnt != 2'h0);
        if (avs_req.write && avs_req.byteenable[0]) begin
            case (avs_req.address)
                ADDR_CSB: begin
                    n.rxcie = avs_req.writedata[CSB_RXCIE];
                    n.rx_en = avs_req.writedata[CSB_RXEN];
                    n.sz[2] = avs_req.writedata[CSB_SZ2];
                end
                ADDR_CSC: begin
                    n.pen = avs_req.writedata[CSC_PEN];
                    n.podd = avs_req.writedata[CSC_PODD];
                    n.sbs = avs_req.writedata[CSC_SBS];
                    n.sz[1:0] = avs_req.writedata[CSC_SZ1:CSC_SZ0];
                end
                ADDR_BAUD: n.baud_div[7:0] = avs_req.writedata[7:0];
                // status a holds no writable bits: error flags ignore writes
                default: n.rxcie = n.rxcie;
            endcase
        end
        if (avs_req.write && avs_req.byteenable[1] && avs_req.address == ADDR_BAUD) begin
            n.baud_div[11:8] = avs_req.writedata[11:8];
        end

        // oversampling divider
        if (r.div_cnt >= r.baud_div) begin
            tick = 1'b1;
            n.div_cnt = '0;
        end else begin
            n.div_cnt = r.div_cnt + 12'h001;
        end

        // head pop on data read, in the wait-state cycle that latches the data
        if (pop) begin
            n.fifo[0] = r.fifo[1];
            n.fifo[1] = '0;
            n.cnt = r.cnt - 2'h1;
        end
        // waiting frame moves into the buffer as soon as there is room
        if (r.hold_v && n.cnt != FIFO_FULL) begin
            e = r.hold;
            e.dor = r.dor_pend;
            n.fifo[n.cnt[0]] = e;
            n.cnt = n.cnt + 2'h1;
            n.hold_v = 1'b0;
            n.dor_pend = 1'b0;
        end

        unique case (r.st)
            URB_IDLE: begin
                if (fall) begin
                    // restart the divider so samples line up with the edge
                    n.st = URB_START;
                    n.samp = SAMP_FIRST;
                    n.div_cnt = '0;
                end
            end
            URB_START, URB_DATA, URB_PAR, URB_STOP: begin
                if (tick) begin
                    n.samp = sn;
                    if (sn == SAMP_A || sn == SAMP_B) begin
                        n.votes = {r.votes[0], r.rx_lvl};
                    end
                    if (sn == SAMP_C) begin
                        if (r.st == URB_START) begin
                            if (bitv) begin
                                n.st = URB_IDLE;
                            end else if (n.hold_v && n.cnt == FIFO_FULL) begin
                                // shifter is about to be reused: waiting frame is lost
                                n.dor_pend = 1'b1;
                                n.hold_v = 1'b0;
                            end
                        end else if (r.st == URB_DATA) begin
                            n.shreg = {bitv, r.shreg[8:1]};
                            n.nbits = r.nbits + 4'h1;
                        end else if (r.st == URB_PAR) begin
                            n.par_bit = bitv;
                        end else begin
                            // first stop bit ends the frame; no wait for a second
                            n.hold.data = aligned[7:0];
                            n.hold.b8 = (r.sz == SZ_9BIT) & aligned[8];
                            n.hold.fe = ~bitv;
                            n.hold.dor = 1'b0;
                            n.hold.pe = r.pen & (r.par_bit ^ (^aligned) ^ r.podd);
                            n.hold_v = 1'b1;
                            n.st = URB_IDLE;
                        end
                    end
                    if (sn == SAMP_END) begin
                        n.samp = '0;
                        if (r.st == URB_START) begin
                            n.st = URB_DATA;
                            n.nbits = '0;
                            n.shreg = '0;
                        end else if (r.st == URB_DATA && r.nbits == need) begin
                            n.st = r.pen ? URB_PAR : URB_STOP;
                        end else if (r.st == URB_PAR) begin
                            n.st = URB_STOP;
                        end
                    end
                end
            end
        endcase

        // disable acts at once and drops everything, pending frame included
        if (!n.rx_en) begin
            n.st = URB_IDLE;
            n.samp = '0;
            n.cnt = '0;
            n.fifo = '0;
            n.hold_v = 1'b0;
            n.dor_pend = 1'b0;
        end
        if (!rst_n) begin
            n = '0;
            n.sync = SYNC_IDLE;
            n.rx_lvl = 1'b1;
            n.rx_prev = 1'b1;
            n.baud_div = BAUD_RST;
        end
    end

    always_ff @(posedge mclk) begin
        r <= n;
    end

    always_comb begin
        avs_rsp.readdata = {20'h00000, r.rdata};
        avs_rsp.waitrequest = avs_req.read & ~r.rd_ack;
        rx_pin_owned = r.rx_en;
        // error flags deliberately kept out of the request
        rx_irq = (r.cnt != 2'h0) & r.rxcie & glob_irq_en;
    end

    rxc_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (pop && r.cnt == 2'h1 && !r.hold_v && r.st != URB_STOP) |=> r.cnt == 2'h0)
        else $error("flag still set after last entry read");
    rxc_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (r.hold_v && r.rx_en && r.cnt == 2'h0 && !pop) ##1 r.rx_en |-> r.cnt == 2'h1)
        else $error("flag not set after frame stored");
    buf_flush_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (avs_req.write && avs_req.byteenable[0] && avs_req.address == ADDR_CSB
         && !avs_req.writedata[CSB_RXEN]) |=> (r.cnt == 2'h0 && !r.hold_v && !rx_irq))
        else $error("buffer not flushed on disable");
    irq_level_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (r.cnt != 2'h0 && r.rxcie && glob_irq_en) [*2] |-> rx_irq)
        else $error("interrupt dropped while flag set");
    err_noirq_a: assert property (@(posedge mclk) disable iff (!rst_n)
        ((r.cnt == 2'h0 || !r.rxcie)
         && (r.fifo[0].fe || r.fifo[0].dor || r.fifo[0].pe || r.dor_pend)) |-> !rx_irq)
        else $error("error flag raised interrupt");
    err_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (avs_req.write && avs_req.address == ADDR_CSA && !pop && r.cnt != 2'h0)
        |=> $stable(r.fifo[0]))
        else $error("status write altered error flags");
    pe_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (avs_req.read && !r.rd_ack && avs_req.address == ADDR_CSA && !r.pen)
        |=> !r.rdata[CSA_PE])
        else $error("parity error visible while parity off");
    empty_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (avs_req.read && !r.rd_ack && avs_req.address == ADDR_DATA && r.cnt == 2'h0
         && !r.hold_v && r.st != URB_STOP)
        |=> (r.cnt == 2'h0 && $stable(r.dor_pend)))
        else $error("empty read changed buffer");
    off_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
        $fell(r.rx_en) |-> (r.st == URB_IDLE && !rx_pin_owned))
        else $error("receiver still active after disable");
    dor_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (r.hold_v && r.cnt != FIFO_FULL && r.rx_en) |=> !r.dor_pend)
        else $error("overrun not cleared on transfer");
    ovr_set_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (r.st == URB_START && tick && sn == SAMP_C && !bitv && r.hold_v
         && r.cnt == FIFO_FULL && !pop && r.rx_en) |=> (r.dor_pend && !r.hold_v))
        else $error("overrun not raised");
    start_rej_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (r.st == URB_START && tick && sn == SAMP_C && bitv) |=> r.st == URB_IDLE)
        else $error("noise spike accepted as start");
    stop_store_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (r.st == URB_STOP && tick && sn == SAMP_C && r.rx_en)
        |=> (r.hold_v && r.st != URB_STOP && r.hold.fe == !$past(bitv)))
        else $error("frame not stored at first stop bit");
    read_wait_a: assert property (@(posedge mclk) disable iff (!rst_n)
        (avs_req.read && !r.rd_ack) |=> (!avs_rsp.waitrequest || !avs_req.read))
        else $error("read not answered after one wait state");
endmodule
`default_nettype wire

// ===== tb/urb_serial_tx.sv
/*
 * urb_serial_tx: behavioural far-end transmitter that drives the receive line.
 * Assumes the bench keeps bit_cyc equal to 16 * (baud divisor + 1) mclk cycles.
 */
`timescale 1ns/100ps
`default_nettype none
module urb_serial_tx (
    input wire logic mclk,
    output var logic rxd
);
    int bit_cyc = 32;

    initial rxd = 1'b1;

    task automatic send_bit(input logic b);
        rxd <= b;
        repeat (bit_cyc) @(posedge mclk);
    endtask

    // lsb first, parity after data, one stop bit, then one idle bit time
    task automatic send(input logic [8:0] d, input int nb, input logic pen, input logic podd,
                        input logic stop);
        logic p;
        p = podd;
        @(posedge mclk);
        send_bit(1'b0);
        for (int i = 0; i < nb; i++) begin
            send_bit(d[i]);
            p = p ^ d[i];
        end
        if (pen) begin
            send_bit(p);
        end
        send_bit(stop);
        // idle gap so a bad stop bit still leaves a clean start edge
        send_bit(1'b1);
    endtask
endmodule
`default_nettype wire

// ===== tb/urb_rx_buffer_tb_top.sv
/*
 * urb_rx_buffer_tb_top: self-checking bench, Avalon-MM master tasks and a serial partner.
 * Assumes the divisor is set to 0x001 so one bit lasts 32 mclk cycles.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin fail_count++; \
    $display("BAD t=%0t got %h exp %h", $time, got, exp); end end
module urb_rx_buffer_tb_top import urb_pkg::*;;
    logic mclk;
    logic rst_n;
    logic glob_irq_en;
    logic rxd;
    logic owned;
    logic irq;
    logic [31:0] rd;
    urb_avs_req_s req;
    urb_avs_rsp_s rsp;
    int fail_count = 0;
    int comparisons = 0;

    urb_rx_buffer dut (.mclk(mclk), .rst_n(rst_n), .rxd_pin(rxd), .glob_irq_en(glob_irq_en),
        .avs_req(req), .avs_rsp(rsp), .rx_pin_owned(owned), .rx_irq(irq));
    urb_serial_tx tx (.mclk(mclk), .rxd(rxd));

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // one idle edge before each request, so release and next request never collide
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge mclk);
        req <= '{a, !wr, wr, wd, 4'hF};
        // waitrequest and read data are taken at the rising edge itself
        do begin
            @(posedge mclk);
            n++;
        end while (rsp.waitrequest !== 1'b0 && n < 100);
        rd = rsp.readdata;
        req <= '{a, 1'b0, 1'b0, wd, 4'hF};
        if (n >= 100) begin
            fail_count++;
        end
    endtask

    task automatic rdchk(input logic [4:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h00000000);
        `CHK(rd, exp)
    endtask

    // the entry lands before the stop bit ends; the poll only confirms it
    task automatic frame(input logic [8:0] d, input int nb, input logic pen, input logic podd,
                         input logic stop);
        int n;
        n = 0;
        tx.send(d, nb, pen, podd, stop);
        do begin
            bus(1'b0, ADDR_CSA, 32'h00000000);
            n++;
        end while (rd[CSA_RXC] !== 1'b1 && n < 40);
        `CHK(rd[CSA_RXC], 1'b1)
    endtask

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask

    task automatic summarize();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge mclk);
        fail_count++;
        summarize();
    end

    initial begin
        rst_n = 1'b0;
        glob_irq_en = 1'b1;
        req = '0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        @(negedge mclk);
        `CHK(owned, 1'b0)
        rdchk(ADDR_CSA, 32'h00000000);
        rdchk(ADDR_DATA, 32'h00000000);
        rdchk(ADDR_CSA, 32'h00000000);
        bus(1'b1, ADDR_BAUD, 32'h00000001);
        bus(1'b1, ADDR_CSC, 32'h00000006);
        bus(1'b1, ADDR_CSB, 32'h00000090);
        rdchk(ADDR_CSB, 32'h00000090);
        @(negedge mclk);
        `CHK(owned, 1'b1)
        done("reset");
        frame(9'h0A5, 8, 1'b0, 1'b0, 1'b1);
        @(negedge mclk);
        `CHK(irq, 1'b1)
        rdchk(ADDR_DATA, 32'h000000A5);
        rdchk(ADDR_CSA, 32'h00000000);
        @(negedge mclk);
        `CHK(irq, 1'b0)
        done("single");
        // stop count set to two: only the first stop bit may count
        bus(1'b1, ADDR_CSC, 32'h0000000E);
        bus(1'b1, ADDR_CSB, 32'h00000010);
        frame(9'h03C, 8, 1'b0, 1'b0, 1'b0);
        frame(9'h0C3, 8, 1'b0, 1'b0, 1'b1);
        @(negedge mclk);
        `CHK(irq, 1'b0)
        bus(1'b1, ADDR_CSA, 32'h00000000);
        rdchk(ADDR_CSA, 32'h00000090);
        rdchk(ADDR_DATA, 32'h0000003C);
        rdchk(ADDR_CSA, 32'h00000080);
        rdchk(ADDR_DATA, 32'h000000C3);
        rdchk(ADDR_CSA, 32'h00000000);
        done("frame error");
        bus(1'b1, ADDR_CSC, 32'h00000026);
        frame(9'h05A, 8, 1'b1, 1'b1, 1'b1);
        rdchk(ADDR_CSA, 32'h00000084);
        bus(1'b1, ADDR_CSC, 32'h00000006);
        rdchk(ADDR_CSA, 32'h00000080);
        rdchk(ADDR_DATA, 32'h0000005A);
        bus(1'b1, ADDR_CSC, 32'h00000036);
        frame(9'h05A, 8, 1'b1, 1'b1, 1'b1);
        rdchk(ADDR_CSA, 32'h00000080);
        rdchk(ADDR_DATA, 32'h0000005A);
        done("parity");
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, ADDR_CSC, 32'(s << 1));
            frame(9'h1FF, 5 + s, 1'b0, 1'b0, 1'b1);
            rdchk(ADDR_DATA, (32'h00000001 << (5 + s)) - 32'h00000001);
        end
        bus(1'b1, ADDR_CSB, 32'h00000094);
        frame(9'h1A5, 9, 1'b0, 1'b0, 1'b1);
        rdchk(ADDR_CSB, 32'h00000096);
        rdchk(ADDR_DATA, 32'h000000A5);
        bus(1'b1, ADDR_CSB, 32'h00000090);
        done("sizes");
        // four frames unread: third is lost when the fourth start arrives
        for (int i = 1; i < 5; i++) begin
            tx.send(9'(i), 8, 1'b0, 1'b0, 1'b1);
        end
        rdchk(ADDR_CSA, 32'h00000080);
        rdchk(ADDR_DATA, 32'h00000001);
        rdchk(ADDR_CSA, 32'h00000080);
        rdchk(ADDR_DATA, 32'h00000002);
        rdchk(ADDR_CSA, 32'h00000088);
        rdchk(ADDR_DATA, 32'h00000004);
        frame(9'h055, 8, 1'b0, 1'b0, 1'b1);
        rdchk(ADDR_CSA, 32'h00000080);
        rdchk(ADDR_DATA, 32'h00000055);
        done("overrun");
        frame(9'h011, 8, 1'b0, 1'b0, 1'b1);
        fork
            tx.send(9'h022, 8, 1'b0, 1'b0, 1'b1);
        join_none
        repeat (150) @(posedge mclk);
        bus(1'b1, ADDR_CSB, 32'h00000080);
        @(negedge mclk);
        `CHK(owned, 1'b0)
        `CHK(irq, 1'b0)
        rdchk(ADDR_CSA, 32'h00000000);
        wait fork;
        bus(1'b1, ADDR_CSB, 32'h00000090);
        rdchk(ADDR_CSA, 32'h00000000);
        done("flush");
        summarize();
    end
endmodule
`default_nettype wire
